// ===== design/ccg_clock_control.sv
// Clock gate and slow mode controller with an AXI4-Lite register port.
// Assumes aclk serves as the peripheral bus clock, the system bus clock
// and the selected slow mode input clock in this build.
`timescale 1ns/100ps
// Function
// - Peripheral bus gates 18..7, reset enabled
// - System bus gates 6..4, reset enabled
// - Real-time-clock gate spares its timer
// - Bit 3 requests power-off, resets 0
// - Idle bit stays until software clears
// - USB off bit stops clock and PLL
// - Main PLL off only in slow mode
// - Slow bit zero selects main PLL
// - Slow clock is input over twice divider, input itself at zero
// - Slow input is crystal or external clock
// - PLL output is m times input over p times two to the s
// - USB lock wait from 12-bit count
// - Idle entry waits for processor acknowledge
module ccg_clock_control (
  input wire logic aclk, // Bus and reference clock, 25 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic clken, // Freezes all state while low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic source_select_pin, // Input clock source strap
  input wire logic idle_ack, // Processor wrapper idle acknowledge
  output logic [ccg_pkg::NUM_GATES-1:0] gated_clock, // Gated clocks
  output logic power_off_request, // Power-off transition request
  output logic idle_request, // Idle entry request
  output logic idle_enter, // Idle entry granted
  output logic special_mode_request, // Special mode bit
  output logic core_clock_from_pll, // Core clock taken from main PLL
  output logic core_clock, // Slow mode core clock
  output logic slow_source_external, // Slow input is external clock
  output logic main_pll_power_down, // Main PLL powered down
  output logic usb_pll_power_down, // USB PLL powered down
  output logic usb_clock_enable // USB clock running
);
  import ccg_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [31:0] clock_gate_control;
  logic [31:0] slow_clock_control;
  logic [11:0] usb_lock_count;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  ccg_usb_state_type usb_state;
  ccg_usb_state_type next_usb_state;
  logic [11:0] lock_timer;
  logic [2:0] div_count;
  logic slow_phase;
  logic [2:0] source_sync;
  logic idle_grant;

  ccg_gate_if gates ();

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire hit_gate_w = aw_addr == ADDR_GATE;
  wire hit_slow_w = aw_addr == ADDR_SLOW;
  wire hit_lock_w = aw_addr == ADDR_LOCK_TIME;
  wire write_hit = hit_gate_w || hit_slow_w || hit_lock_w;
  wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                           {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] next_gate = (clock_gate_control & ~(strb_mask & GATE_MASK))
                        | (w_data & strb_mask & GATE_MASK);
  wire [31:0] next_slow = (slow_clock_control & ~(strb_mask & SLOW_MASK))
                        | (w_data & strb_mask & SLOW_MASK);
  wire [31:0] lock_word = {8'h00, usb_lock_count, 12'h000};
  wire [31:0] next_lock_word = (lock_word & ~strb_mask)
                             | (w_data & strb_mask);

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (clken) begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clken) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // The idle bit is only ever changed by a bus write, never by the
  // idle handshake, so software sees exactly what it wrote.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_gate_control <= GATE_RESET;
      slow_clock_control <= SLOW_RESET;
      usb_lock_count <= LOCK_RESET;
    end else if (clken && do_write) begin
      if (hit_gate_w) begin
        clock_gate_control <= next_gate;
      end
      if (hit_slow_w) begin
        slow_clock_control <= next_slow;
      end
      if (hit_lock_w) begin
        usb_lock_count <= next_lock_word[LOCK_HI:LOCK_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire hit_gate_r = s_axi_araddr == ADDR_GATE;
  wire hit_slow_r = s_axi_araddr == ADDR_SLOW;
  wire hit_lock_r = s_axi_araddr == ADDR_LOCK_TIME;
  wire read_hit = hit_gate_r || hit_slow_r || hit_lock_r;
  wire [31:0] read_word = hit_gate_r ? (clock_gate_control & GATE_MASK) :
                          hit_slow_r ? (slow_clock_control & SLOW_MASK) :
                          hit_lock_r ? lock_word : 32'h0000_0000;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clken) begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Peripheral clock gates
  // ----------------------------------------------------------------
  // gate enables
  assign gates.enable = clock_gate_control[GATE_HI:GATE_LO];
  // bus clock only
  // The timer of the real-time clock runs from its own oscillator and
  // is never touched here; only its register clock is gated.
  assign gated_clock = gates.gated;

  ccg_clock_gate u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .clken(clken),
    .gates(gates.gate)
  );

  // ----------------------------------------------------------------
  // Power mode requests
  // ----------------------------------------------------------------
  // power-off request
  assign power_off_request = clock_gate_control[BIT_POWER_OFF];
  assign idle_request = clock_gate_control[BIT_IDLE];
  assign special_mode_request = clock_gate_control[BIT_SPECIAL];
  assign idle_enter = idle_grant;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_grant <= 1'b0;
    end else if (clken) begin
      idle_grant <= clock_gate_control[BIT_IDLE] && idle_ack;
    end
  end

  // ----------------------------------------------------------------
  // Slow mode and main PLL
  // ----------------------------------------------------------------
  wire slow_mode = slow_clock_control[BIT_SLOW];
  wire [2:0] slow_divider_value = slow_clock_control[DIV_HI:0];
  wire div_wrap = div_count == (slow_divider_value - 3'h1);

  assign core_clock_from_pll = !slow_mode;
  assign main_pll_power_down = slow_clock_control[BIT_MPLL_OFF] && slow_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= 3'h0;
      slow_phase <= 1'b0;
    end else if (clken) begin
      if (slow_divider_value == 3'h0 || div_wrap) begin
        div_count <= 3'h0;
        slow_phase <= !slow_phase;
      end else begin
        div_count <= div_count + 3'h1;
      end
    end
  end

  // A zero divider passes the input clock straight through; the
  // switch to or from zero may clip one phase, as the mode is only
  // changed while the core runs from the main PLL.
  assign core_clock = (slow_divider_value == 3'h0) ? aclk : slow_phase;

  // input clock source
  // The strap is asynchronous, so it passes three flops and a change
  // counts once the last two agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_sync <= 3'h0;
      slow_source_external <= 1'b0;
    end else if (clken) begin
      source_sync <= {source_sync[1:0], source_select_pin};
      if (source_sync[1] == source_sync[2]) begin
        slow_source_external <= source_sync[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // USB clock and PLL
  // ----------------------------------------------------------------
  wire usb_clock_off_select = slow_clock_control[BIT_USB_OFF];

  always_comb begin
    next_usb_state = usb_state;
    case (usb_state)
      USB_STOPPED: begin
        if (!usb_clock_off_select) next_usb_state = USB_LOCKING;
      end
      USB_LOCKING: begin
        if (usb_clock_off_select) next_usb_state = USB_STOPPED;
        else if (lock_timer == 12'h000) next_usb_state = USB_RUNNING;
      end
      USB_RUNNING: begin
        if (usb_clock_off_select) next_usb_state = USB_STOPPED;
      end
      default: next_usb_state = USB_STOPPED;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_state <= USB_LOCKING;
      lock_timer <= LOCK_RESET;
    end else if (clken) begin
      usb_state <= next_usb_state;
      if (usb_state != USB_LOCKING) begin
        lock_timer <= usb_lock_count;
      end else if (lock_timer != 12'h000) begin
        lock_timer <= lock_timer - 12'h001;
      end
    end
  end

  assign usb_pll_power_down = usb_state == USB_STOPPED;
  assign usb_clock_enable = usb_state == USB_RUNNING;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_pll_law;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |-> ccg_pll_khz(12000, 120, 2, 3) == 48000;
  endproperty
  a_pll_law: assert property (p_pll_law)
    else $error("PLL output law gives wrong frequency");

  property p_gate_reset;
    @(posedge aclk) $rose(aresetn) |-> gates.enable == 15'h7fff;
  endproperty
  a_gate_reset: assert property (p_gate_reset)
    else $error("Gate enables not all set after reset");

  property p_hbus_gate_follows;
    @(posedge aclk) disable iff (!aresetn)
      clken && do_write && hit_gate_w && w_strb[0] |=>
        gates.enable[2:0] == $past(w_data[6:4]);
  endproperty
  a_hbus_gate_follows: assert property (p_hbus_gate_follows)
    else $error("System bus gate did not follow write");

  property p_idle_sticky;
    @(posedge aclk) disable iff (!aresetn)
      idle_request && !(do_write && hit_gate_w) |=> idle_request;
  endproperty
  a_idle_sticky: assert property (p_idle_sticky)
    else $error("Idle request cleared without a write");

  property p_idle_ack;
    @(posedge aclk) disable iff (!aresetn)
      idle_enter |-> $past(idle_ack) && $past(idle_request);
  endproperty
  a_idle_ack: assert property (p_idle_ack)
    else $error("Idle entered without acknowledge");

  property p_mpll_off;
    @(posedge aclk) disable iff (!aresetn)
      main_pll_power_down |-> slow_mode;
  endproperty
  a_mpll_off: assert property (p_mpll_off)
    else $error("Main PLL down outside slow mode");

  property p_usb_off;
    @(posedge aclk) disable iff (!aresetn)
      clken && usb_clock_off_select |=>
        usb_pll_power_down && !usb_clock_enable;
  endproperty
  a_usb_off: assert property (p_usb_off)
    else $error("USB clock still running after off select");

  property p_usb_lock;
    @(posedge aclk) disable iff (!aresetn)
      clken && usb_pll_power_down && !usb_clock_off_select &&
        usb_lock_count == 12'h002 |=>
        !usb_clock_enable [*3];
  endproperty
  a_usb_lock: assert property (p_usb_lock)
    else $error("USB clock enabled before lock wait");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rresp == RESP_OKAY |->
        s_axi_rdata[31:24] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved read bits not zero");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
      clken && do_write |=> s_axi_bvalid &&
        (!$past(hit_gate_w && w_strb[0]) ||
         power_off_request == $past(w_data[BIT_POWER_OFF]));
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("Write not answered or power-off bit not taken");

  c_slow_entry: cover property (@(posedge aclk) $rose(slow_mode));
  c_usb_run: cover property (@(posedge aclk) $rose(usb_clock_enable));
  c_idle: cover property (@(posedge aclk) $rose(idle_enter));

endmodule : ccg_clock_control

// ===== include/ccg_pkg.sv
// Constants, field layout and state types of the clock gate and slow
// mode controller. Assumes a 25 MHz register bus clock.
package ccg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // Settling time software waits before leaving slow mode.
  localparam int unsigned PLL_SETTLE_NS = 150_000;
  localparam int unsigned PLL_SETTLE_CYCLES =
    (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_LOCK_TIME = 32'h4c00_0000;
  localparam logic [31:0] ADDR_GATE = 32'h4c00_000c;
  localparam logic [31:0] ADDR_SLOW = 32'h4c00_0010;

  // ----------------------------------------------------------------
  // Clock gate control fields
  // ----------------------------------------------------------------
  localparam int unsigned NUM_GATES = 15;
  localparam int unsigned GATE_LO = 4;
  localparam int unsigned GATE_HI = 18;
  localparam int unsigned GATE_PBUS_LO = 7;
  localparam int unsigned GATE_RTC = 14;
  localparam int unsigned BIT_POWER_OFF = 3;
  localparam int unsigned BIT_IDLE = 2;
  localparam int unsigned BIT_SPECIAL = 0;
  localparam logic [31:0] GATE_RESET = 32'h0007_fff0;
  localparam logic [31:0] GATE_MASK = 32'h0007_fffd;

  // ----------------------------------------------------------------
  // Slow clock control fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_USB_OFF = 7;
  localparam int unsigned BIT_MPLL_OFF = 5;
  localparam int unsigned BIT_SLOW = 4;
  localparam int unsigned DIV_HI = 2;
  localparam logic [31:0] SLOW_RESET = 32'h0000_0004;
  localparam logic [31:0] SLOW_MASK = 32'h0000_00b7;

  // ----------------------------------------------------------------
  // Lock time field
  // ----------------------------------------------------------------
  localparam int unsigned LOCK_LO = 12;
  localparam int unsigned LOCK_HI = 23;
  localparam logic [11:0] LOCK_RESET = 12'hfff;

  // ----------------------------------------------------------------
  // PLL output law and bus answers
  // ----------------------------------------------------------------
  localparam int unsigned PLL_M_OFFSET = 8;
  localparam int unsigned PLL_P_OFFSET = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    USB_STOPPED = 3'h1,
    USB_LOCKING = 3'h2,
    USB_RUNNING = 3'h4
  } ccg_usb_state_type;

  // Output frequency in kHz from input kHz and raw divider fields.
  function automatic int unsigned ccg_pll_khz(
    input int unsigned fin_khz,
    input int unsigned main_div,
    input int unsigned pre_div,
    input int unsigned post_div
  );
    ccg_pll_khz = ((main_div + PLL_M_OFFSET) * fin_khz) /
      ((pre_div + PLL_P_OFFSET) << post_div);
  endfunction : ccg_pll_khz

endpackage : ccg_pkg

// ===== include/ccg_gate_if.sv
// Carries gate enables to the glitch-free gate cells and the gated
// clocks back. Assumes both ends share the bus clock.
`timescale 1ns/100ps
interface ccg_gate_if;
  logic [ccg_pkg::NUM_GATES-1:0] enable;
  logic [ccg_pkg::NUM_GATES-1:0] gated;
  modport ctrl (output enable, input gated);
  modport gate (input enable, output gated);
endinterface : ccg_gate_if

// ===== design/ccg_clock_gate.sv
// Glitch-free clock gate cells, one per gated peripheral clock.
// Assumes the enables change only just after a rising clock edge.
`timescale 1ns/100ps
module ccg_clock_gate (
  input wire logic aclk, // Clock to be gated
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic clken, // Freezes the enable latches while low
  ccg_gate_if.gate gates // Enables in, gated clocks out
);
  import ccg_pkg::*;

  logic [NUM_GATES-1:0] hold;

  // ----------------------------------------------------------------
  // Gate cells
  // ----------------------------------------------------------------
  // The enable is taken on the falling edge, while the clock is low,
  // so the AND never cuts a high phase short.
  genvar i;
  generate
    for (i = 0; i < NUM_GATES; i++) begin : g_cell
      always_ff @(negedge aclk) begin
        if (!aresetn) begin
          hold[i] <= 1'b1;
        end else if (clken) begin
          hold[i] <= gates.enable[i];
        end
      end
      assign gates.gated[i] = aclk & hold[i];
    end
  endgenerate

endmodule : ccg_clock_gate

// ===== bench/ccg_clock_control_bench.sv
// Self-checking bench for the clock gate and slow mode controller.
// Assumes ccg_pkg and the design files are compiled before it.
`timescale 1ns/100ps
`define chk(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module ccg_clock_control_bench;
  import ccg_pkg::*;
  logic aclk, aresetn, clken, source_select_pin, idle_ack;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, power_off_request, idle_request, idle_enter;
  logic special_mode_request, core_clock_from_pll, core_clock;
  logic slow_source_external, main_pll_power_down;
  logic usb_pll_power_down, usb_clock_enable;
  logic [NUM_GATES-1:0] gated_clock;
  int err_total, compares;

  ccg_clock_control dut_u (.aclk, .aresetn, .clken, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .source_select_pin, .idle_ack, .gated_clock, .power_off_request,
    .idle_request, .idle_enter, .special_mode_request,
    .core_clock_from_pll, .core_clock, .slow_source_external,
    .main_pll_power_down, .usb_pll_power_down, .usb_clock_enable);

  always #20 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar;
    ar = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin
        ar = 0;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic wrchk(input logic [31:0] a, d);
    logic [1:0] r;
    wr(a, d, r);
    `chk("bresp", RESP_OKAY, r)
  endtask : wrchk

  task automatic rdchk(input logic [31:0] a, e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `chk("rresp", RESP_OKAY, r)
    `chk("rdata", e, d)
  endtask : rdchk

  // Looks mid high phase and mid low phase of the gated clocks.
  task automatic gchk(input logic [31:0] v);
    repeat (2) @(posedge aclk);
    #10;
    `chk("gated_high", v[18:4], gated_clock)
    `chk("power_off", v[3], power_off_request)
    `chk("idle", v[2], idle_request)
    `chk("special", v[0], special_mode_request)
    @(negedge aclk);
    #10;
    `chk("gated_low", 15'h0, gated_clock)
    @(posedge aclk);
  endtask : gchk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d, v;
    logic [1:0] r;
    int n;
    realtime t0;
    aclk = 0;
    aresetn = 0;
    clken = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, source_select_pin, idle_ack} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    compares = 0;
    void'($urandom(32'hbbd322a2));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(ADDR_GATE, GATE_RESET);
    rdchk(ADDR_SLOW, SLOW_RESET);
    gchk(GATE_RESET);
    // A short lock count keeps the USB relock checks quick.
    wrchk(ADDR_LOCK_TIME, 32'h2000);
    for (n = 0; n < 6000 && usb_clock_enable !== 1'b1; n++) @(posedge aclk);
    `chk("usb_on", 1'b1, usb_clock_enable)
    `chk("usb_pll_khz", 48000, ccg_pll_khz(12000, 120, 2, 3))
    `chk("core_pll_khz", 266000, ccg_pll_khz(12000, 125, 1, 1))
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
      d[0] = 1'b0;
      wrchk(ADDR_GATE, d);
      rdchk(ADDR_GATE, d & GATE_MASK);
      gchk(d);
    end
    wrchk(ADDR_GATE, 32'h4);
    idle_ack <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    `chk("idle_enter", 1'b1, idle_enter)
    @(posedge aclk);
    idle_ack <= 1'b0;
    repeat (20) @(posedge aclk);
    #1;
    `chk("idle_enter", 1'b0, idle_enter)
    @(posedge aclk);
    rdchk(ADDR_GATE, 32'h4);
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      d = (v & 32'hffffff68) | 32'(i % 8) | ((i < 8 || v[4]) ? 32'h10 : 0);
      if (i >= 6 && d[4]) d[5] = 1'b0;
      wrchk(ADDR_SLOW, d);
      if (i == 7) repeat (PLL_SETTLE_CYCLES) @(posedge aclk);
      rdchk(ADDR_SLOW, d & SLOW_MASK);
      #1;
      `chk("from_pll", !d[4], core_clock_from_pll)
      `chk("mpll_down", d[5] & d[4], main_pll_power_down)
      if (d[4]) begin
        repeat (2) @(posedge core_clock);
        t0 = $realtime;
        @(posedge core_clock);
        n = $rtoi($realtime - t0);
        `chk("core_period", (d[2:0] == 0) ? 40 : 80 * d[2:0], n)
      end
      @(posedge aclk);
    end
    wrchk(ADDR_SLOW, 32'h84);
    repeat (2) @(posedge aclk);
    #1;
    `chk("usb_pll_down", 1'b1, usb_pll_power_down)
    `chk("usb_clk", 1'b0, usb_clock_enable)
    @(posedge aclk);
    wrchk(ADDR_SLOW, 32'h04);
    #1;
    `chk("usb_pll_down", 1'b0, usb_pll_power_down)
    `chk("usb_clk", 1'b0, usb_clock_enable)
    for (n = 0; n < 20 && usb_clock_enable !== 1'b1; n++) @(posedge aclk);
    `chk("usb_clk", 1'b1, usb_clock_enable)
    @(posedge aclk);
    wr(32'h4c000020, $urandom, r);
    `chk("bad_bresp", RESP_SLVERR, r)
    rd(32'h4c000020, d, r);
    `chk("bad_rresp", RESP_SLVERR, r)
    `chk("bad_rdata", 32'h0, d)
    for (int i = 0; i < 4; i++) begin
      source_select_pin <= ~i[0];
      for (n = 0; n < 32 && slow_source_external !== ~i[0]; n++) begin
        @(posedge aclk);
      end
      `chk("source", ~i[0], slow_source_external)
      @(posedge aclk);
    end
    end_of_test();
  end

  // Covers the long reset lock count plus every scenario with margin.
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
endmodule : ccg_clock_control_bench
